/* rtl/oat_pkg.sv */
// Shared constants, encodings and the per-output configuration word.
// Assumes one 100 MHz clock; every slower rate comes from enable pulses.
package oat_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int N_OUT  = 96;   // Independently configured outputs
    localparam int N_ZONE = 129;  // Zones 000 to 128
    localparam int N_LIST = 15;   // Zone lists 01 to 15
    localparam int ZONE_W = 8;
    localparam int IDX_W  = 7;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ    = 100_000_000;
    localparam int TICK_MS   = 250;                        // Pulsing half period
    localparam int TICK_CYC  = (CLK_HZ / 1000) * TICK_MS;  // Cycles per tick
    localparam int MOM_MS    = 2000;                       // Momentary on time
    localparam int MOM_TICKS = MOM_MS / TICK_MS;
    localparam logic [3:0] MOM_LAST = 4'(MOM_TICKS - 1);

    // ****************************************************************
    // Encodings
    // ****************************************************************
    typedef enum logic [2:0] {
        ACT_MOMENT = 3'h0,
        ACT_LATCH  = 3'h1,
        ACT_PULSE  = 3'h2,
        ACT_NONE   = 3'h3,
        ACT_TOGGLE = 3'h4
    } oat_action_t;

    typedef enum logic [2:0] {
        EVK_ALARM   = 3'h0,
        EVK_FAULT   = 3'h1,
        EVK_TROUBLE = 3'h2,
        EVK_RESTORE = 3'h3,
        EVK_SYSOP   = 3'h4
    } oat_evkind_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_LIST = 2'h1,
        SRC_ZONE = 2'h2
    } oat_src_t;

    typedef enum logic [1:0] {
        DEV_OFF   = 2'h0,
        DEV_RELAY = 2'h1,
        DEV_ANNUN = 2'h2,
        DEV_PLC   = 2'h3
    } oat_dev_t;

    // Bus address windows of expansion modules
    localparam logic [4:0] RELAY_ADDR_MIN = 5'h01;
    localparam logic [4:0] RELAY_ADDR_MAX = 5'h0f;
    localparam logic [4:0] ANNUN_ADDR_MIN = 5'h08;
    localparam logic [4:0] ANNUN_ADDR_MAX = 5'h17;

    // Type/operation code: 0 none, bit 5 clear zone type, bit 5 set operation
    localparam int ZT_SYSOP_BIT = 5;

    typedef struct packed {
        oat_action_t       action;
        oat_src_t          st_src;
        oat_evkind_t       trigger_event_select;
        logic [3:0]        zone_group_select;
        logic [ZONE_W-1:0] st_zone;
        logic [5:0]        st_type_or_sysop;
        logic [3:0]        st_part;
        logic [3:0]        sp_list;
        logic [5:0]        sp_type_or_sysop;
        logic [3:0]        sp_part;
        oat_dev_t          dev;
        logic [4:0]        dev_addr;
        logic [3:0]        house;
        logic [3:0]        unit;
    } oat_cfg_t;

endpackage

/* rtl/oat_cfg_if.sv */
// Configuration memory port between the trigger engine and its store.
// Assumes both ends share the single system clock.
`timescale 1ns/1ns
interface oat_cfg_if;
    import oat_pkg::*;
    logic                 we;
    logic [IDX_W-1:0]     waddr;
    oat_cfg_t             wdata;
    logic [IDX_W-1:0]     raddr;
    oat_cfg_t             rdata;

    modport engine (output we, output waddr, output wdata, output raddr, input rdata);
    modport store  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* rtl/oat_cfg_mem.sv */
// Per-output configuration store, one word per output.
// Assumes synchronous write and one-cycle registered read.
`timescale 1ns/1ns
module oat_cfg_mem
    import oat_pkg::*;
#(
    parameter int DEPTH = N_OUT
)(
    input  wire logic  clock,
    oat_cfg_if.store   port
);

    oat_cfg_t mem_q [DEPTH];
    oat_cfg_t rd_q;

    // ****************************************************************
    // Storage and registered read
    // ****************************************************************
    // No reset on the array: software loads it before use
    always_ff @(posedge clock)
    begin
        if (port.we && (int'(port.waddr) < DEPTH))
            mem_q[port.waddr] <= port.wdata;
        rd_q <= mem_q[port.raddr];
    end

    assign port.rdata = rd_q;

endmodule

/* rtl/oat_trigger.sv */
// Output action trigger engine: scans every output per event or tick.
// Assumes event and config inputs come from logic on the same clock.
`timescale 1ns/1ns
// Summary of operation
// - Momentary action holds output on two seconds after start, then drops it.
// - Latch action turns on at start, stays on until stop.
// - Pulsing alternates from start to stop; annunciator outputs never pulse.
// - No-response action never changes its output.
// - Toggle action inverts output at each start.
// - Fifteen zone lists; start fires on event in any listed zone.
// - Event select is alarm, fault, trouble or restore, for list or zone.
// - Single zone 000 to 128 with selected event may start output.
// - Zone type start fires on any such zone in alarm, trouble, fault.
// - System operation start fires whenever that operation occurs.
// - Start type or operation filtered to partition 1-8; 0 means any.
// - Type/operation start and event/list start evaluated in parallel.
// - Stop list deactivates only when every zone of the list restored.
// - Zone type stop fires when any zone of that type restores.
// - System operation stop fires whenever that operation occurs.
// - Stop type or operation filtered to partition 1-8; 0 means any.
// - Type/operation stop independent of restore-list stop.
// - Relay module address 01-15 drives only when enabled.
// - Annunciator address 08-23 drives only when enabled.
// - Powerline outputs send on/off commands with house and unit code.
// - Ninety-six outputs, each with own action, start and stop.
module oat_trigger
    import oat_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)(
    input  wire logic                 clock,
    input  wire logic                 rstn,
    input  wire logic                 cfg_we,
    input  wire logic [IDX_W-1:0]     cfg_addr,
    input  wire oat_cfg_t             cfg_wdata,
    input  wire logic                 list_we,
    input  wire logic [3:0]           list_idx,
    input  wire logic [N_ZONE-1:0]    list_bits,
    input  wire logic [15:0]          relay_addr_en,
    input  wire logic [31:0]          annun_addr_en,
    input  wire logic                 evt_valid,
    input  wire oat_evkind_t          evt_kind,
    input  wire logic [ZONE_W-1:0]    evt_zone,
    input  wire logic [4:0]           evt_type_or_op,
    input  wire logic [3:0]           evt_part,
    output logic                      evt_ready_q,
    output logic [N_OUT-1:0]          out_q,
    output logic                      plc_valid_q,
    output logic                      plc_on_q,
    output logic [3:0]                plc_house_q,
    output logic [3:0]                plc_unit_q
);

    // ****************************************************************
    // Decoding functions
    // ****************************************************************
    // Partition 0 accepts any partition
    function automatic logic part_ok(input logic [3:0] want, input logic [3:0] got);
        part_ok = (want == 4'h0) || (want == got);
    endfunction

    // Type or operation code against the event held in the scan
    function automatic logic zt_hit(input logic [5:0] code, input oat_evkind_t k,
                                    input logic [4:0] t, input logic restore);
        logic is_op;
        is_op = code[ZT_SYSOP_BIT];
        if (code == 6'h00)
            zt_hit = 1'b0;
        else if (is_op)
            zt_hit = (k == EVK_SYSOP) && (code[4:0] == t);
        else if (restore)
            zt_hit = (k == EVK_RESTORE) && (code[4:0] == t);
        else
            zt_hit = (k == EVK_ALARM || k == EVK_FAULT || k == EVK_TROUBLE)
                     && (code[4:0] == t);
    endfunction

    // Enabled module address inside the window of its kind
    function automatic logic addr_ok(input oat_dev_t d, input logic [4:0] a,
                                     input logic [15:0] rm, input logic [31:0] am);
        unique case (d)
            DEV_RELAY: addr_ok = (a >= RELAY_ADDR_MIN) && (a <= RELAY_ADDR_MAX)
                                 && rm[a[3:0]];
            DEV_ANNUN: addr_ok = (a >= ANNUN_ADDR_MIN) && (a <= ANNUN_ADDR_MAX) && am[a];
            DEV_PLC:   addr_ok = 1'b1;
            DEV_OFF:   addr_ok = 1'b0;
        endcase
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic {
        S_IDLE = 1'b0,
        S_SCAN = 1'b1
    } oat_state_t;

    oat_state_t         st_q, st_d;
    logic [N_ZONE-1:0]  list_q [N_LIST+1];
    logic [N_ZONE-1:0]  active_q;
    logic [N_OUT-1:0]   on_q, run_q, en_q;
    logic [3:0]         cnt_q [N_OUT];
    logic [31:0]        tick_cnt_q;
    logic               tick_pend_q, tick_run_q, ev_run_q;
    oat_evkind_t        ev_kind_q;
    logic [ZONE_W-1:0]  ev_zone_q;
    logic [4:0]         ev_type_q;
    logic [3:0]         ev_part_q;
    logic [IDX_W:0]     idx_q;
    logic               v1_q;
    logic [IDX_W-1:0]   i1_q;

    oat_cfg_if cfg_bus ();

    oat_cfg_mem #(
        .DEPTH (N_OUT)
    ) u_mem (
        .clock (clock),
        .port  (cfg_bus.store)
    );

    // ****************************************************************
    // Scan control and shared tick
    // ****************************************************************
    wire        accept   = evt_valid && evt_ready_q;
    wire        issuing  = (st_q == S_SCAN) && (idx_q < (IDX_W + 1)'(N_OUT));
    wire        scan_end = (st_q == S_SCAN) && (idx_q == (IDX_W + 1)'(N_OUT));
    wire        tick     = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    wire        zone_ok  = (32'(evt_zone) < 32'(N_ZONE));

    assign cfg_bus.we    = cfg_we;
    assign cfg_bus.waddr = cfg_addr;
    assign cfg_bus.wdata = cfg_wdata;
    assign cfg_bus.raddr = idx_q[IDX_W-1:0];

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            S_IDLE: if (accept || tick_pend_q) st_d = S_SCAN;
            S_SCAN: if (scan_end) st_d = S_IDLE;
        endcase
    end

    // Sequencer, tick divider and event capture
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q        <= S_IDLE;
            idx_q       <= '0;
            v1_q        <= 1'b0;
            i1_q        <= '0;
            tick_cnt_q  <= '0;
            tick_pend_q <= 1'b0;
            tick_run_q  <= 1'b0;
            ev_run_q    <= 1'b0;
            evt_ready_q <= 1'b0;
            ev_kind_q   <= EVK_ALARM;
            ev_zone_q   <= '0;
            ev_type_q   <= '0;
            ev_part_q   <= '0;
        end
        else
        begin
            st_q        <= st_d;
            v1_q        <= issuing;
            i1_q        <= idx_q[IDX_W-1:0];
            tick_cnt_q  <= tick ? '0 : tick_cnt_q + 32'h1;
            evt_ready_q <= (st_d == S_IDLE) && !accept;
            if (st_q == S_IDLE && st_d == S_SCAN)
            begin
                idx_q      <= '0;
                tick_run_q <= tick_pend_q;
                ev_run_q   <= accept;
            end
            else if (issuing)
                idx_q <= idx_q + (IDX_W + 1)'(1);
            // A tick landing on the cycle its flag is consumed is kept
            if (tick)
                tick_pend_q <= 1'b1;
            else if (st_q == S_IDLE && st_d == S_SCAN)
                tick_pend_q <= 1'b0;
            if (accept)
            begin
                ev_kind_q <= evt_kind;
                ev_zone_q <= evt_zone;
                ev_type_q <= evt_type_or_op;
                ev_part_q <= evt_part;
            end
        end
    end

    // ****************************************************************
    // Zone lists and zone condition memory
    // ****************************************************************
    // Index 0 is never written so list 0 stands for none
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int l = 0; l <= N_LIST; l++)
                list_q[l] <= '0;
            active_q <= '0;
        end
        else
        begin
            if (list_we && list_idx != 4'h0)
                list_q[list_idx] <= list_bits;
            if (accept && zone_ok && evt_kind != EVK_SYSOP)
                active_q[evt_zone] <= (evt_kind != EVK_RESTORE);
        end
    end

    // ****************************************************************
    // Per-output evaluation
    // ****************************************************************
    oat_cfg_t c;
    assign c = cfg_bus.rdata;

    wire               ev_zone_kind = ev_run_q && (ev_kind_q != EVK_SYSOP);
    wire [N_ZONE-1:0]  st_list      = list_q[c.zone_group_select];
    wire [N_ZONE-1:0]  sp_list      = list_q[c.sp_list];
    wire               ev_in_range  = (32'(ev_zone_q) < 32'(N_ZONE));
    // Event plus list, or event plus one zone
    wire start_evt = ev_zone_kind && ev_in_range
                     && (ev_kind_q == c.trigger_event_select)
                     && (((c.st_src == SRC_LIST) && st_list[ev_zone_q])
                     || ((c.st_src == SRC_ZONE) && (c.st_zone == ev_zone_q)));
    // Type or operation start, own partition filter
    wire start_zt  = ev_run_q && part_ok(c.st_part, ev_part_q)
                     && zt_hit(c.st_type_or_sysop, ev_kind_q, ev_type_q, 1'b0);
    wire start_hit = start_evt || start_zt;
    // Last listed zone restored and nothing of the list still active
    wire stop_list = ev_zone_kind && ev_in_range && (c.sp_list != 4'h0)
                     && (ev_kind_q == EVK_RESTORE) && sp_list[ev_zone_q]
                     && ((sp_list & active_q) == '0);
    wire stop_zt   = ev_run_q && part_ok(c.sp_part, ev_part_q)
                     && zt_hit(c.sp_type_or_sysop, ev_kind_q, ev_type_q, 1'b1);
    wire stop_hit  = stop_list || stop_zt;

    logic       on_o, run_o, on_n, run_n;
    logic [3:0] cnt_o, cnt_n;
    assign on_o  = on_q[i1_q];
    assign run_o = run_q[i1_q];
    assign cnt_o = cnt_q[i1_q];

    // Next state by action; a tick is applied before the event
    always_comb
    begin
        on_n  = on_o;
        run_n = run_o;
        cnt_n = cnt_o;
        unique case (c.action)
            ACT_MOMENT:
            begin
                if (tick_run_q && on_o)
                begin
                    cnt_n = cnt_o + 4'h1;
                    if (cnt_o == MOM_LAST)
                        on_n = 1'b0;
                end
                if (start_hit)
                begin
                    on_n  = 1'b1;
                    cnt_n = 4'h0;
                end
            end
            ACT_LATCH:
            begin
                if (start_hit)
                    on_n = 1'b1;
                if (stop_hit)
                    on_n = 1'b0;
            end
            ACT_PULSE:
            begin
                if (tick_run_q && run_o && c.dev != DEV_ANNUN)
                    on_n = !on_o;
                if (start_hit && !run_o)
                begin
                    run_n = 1'b1;
                    on_n  = 1'b1;
                end
                if (stop_hit)
                begin
                    run_n = 1'b0;
                    on_n  = 1'b0;
                end
            end
            ACT_TOGGLE:
                if (start_hit)
                    on_n = !on_o;
            ACT_NONE: ;
            default: ;                                                 // Unused codes hold
        endcase
    end

    // ****************************************************************
    // Output state and powerline commands
    // ****************************************************************
    // Gating by enable keeps disabled module addresses dark
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            on_q        <= '0;
            run_q       <= '0;
            en_q        <= '0;
            for (int n = 0; n < N_OUT; n++)
                cnt_q[n] <= '0;
            out_q       <= '0;
            plc_valid_q <= 1'b0;
            plc_on_q    <= 1'b0;
            plc_house_q <= '0;
            plc_unit_q  <= '0;
        end
        else
        begin
            out_q       <= on_q & en_q;
            plc_valid_q <= 1'b0;
            if (v1_q)
            begin
                on_q[i1_q]  <= on_n;
                run_q[i1_q] <= run_n;
                cnt_q[i1_q] <= cnt_n;
                en_q[i1_q]  <= addr_ok(c.dev, c.dev_addr, relay_addr_en,
                                       annun_addr_en);
                if (c.dev == DEV_PLC && on_n != on_o)
                begin
                    plc_valid_q <= 1'b1;
                    plc_on_q    <= on_n;
                    plc_house_q <= c.house;
                    plc_unit_q  <= c.unit;
                end
            end
        end
    end

endmodule

/* sim/oat_trigger_chk.sv */
// Port timing checker for the output action trigger engine.
// Assumes it is bound into oat_trigger and sees only its top ports.
`timescale 1ns/1ns
module oat_trigger_chk
    import oat_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)(
    input wire logic             clock,
    input wire logic             rstn,
    input wire logic             evt_valid,
    input wire logic             evt_ready_q,
    input wire logic [N_OUT-1:0] out_q,
    input wire logic             plc_valid_q,
    input wire logic             plc_on_q,
    input wire logic [3:0]       plc_house_q,
    input wire logic [3:0]       plc_unit_q
);
    logic [7:0] low_cnt_q;
    int         high_cnt_q;

    // Ready run lengths; low count saturates so reset is no short scan
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            low_cnt_q  <= 8'hff;
            high_cnt_q <= 0;
        end
        else
        begin
            low_cnt_q  <= evt_ready_q ? 8'h00
                        : ((&low_cnt_q) ? low_cnt_q : low_cnt_q + 8'h01);
            high_cnt_q <= evt_ready_q ? high_cnt_q + 1 : 0;
        end
    end

    // A taken event must close the port for a whole scan of all outputs
    a_ready_drops: assert property (@(posedge clock) disable iff (!rstn)
        evt_valid && evt_ready_q |=> !evt_ready_q) else $error("ready held after accept");
    a_scan_long: assert property (@(posedge clock) disable iff (!rstn)
        $rose(evt_ready_q) |-> low_cnt_q >= 8'h5f) else $error("scan too short");
    a_scan_ends: assert property (@(posedge clock) disable iff (!rstn)
        $fell(evt_ready_q) |-> ##[90:110] evt_ready_q) else $error("scan did not finish");
    a_tick_due: assert property (@(posedge clock) disable iff (!rstn)
        high_cnt_q <= TICK_CYCLES) else $error("tick scan overdue");
    a_reset_clear: assert property (@(posedge clock) disable iff (!rstn)
        $rose(rstn) |-> out_q == '0 && !plc_valid_q) else $error("outputs set after reset");
    a_ready_at_start: assert property (@(posedge clock) disable iff (!rstn)
        $rose(rstn) |=> evt_ready_q) else $error("ready late after reset");
    a_plc_in_scan: assert property (@(posedge clock) disable iff (!rstn)
        plc_valid_q |-> !evt_ready_q || !$past(evt_ready_q) || !$past(evt_ready_q, 2))
        else $error("powerline command outside scan");
    a_plc_codes_stand: assert property (@(posedge clock) disable iff (!rstn)
        !plc_valid_q |-> $stable({plc_on_q, plc_house_q, plc_unit_q}))
        else $error("powerline codes moved");
endmodule

bind oat_trigger oat_trigger_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

/* sim/oat_out_model.sv */
// Far-side model: powerline receivers keyed by house and unit code.
// Assumes the engine's command port runs on the same single clock.
`timescale 1ns/1ns
module oat_out_model
(
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       plc_valid_q,
    input wire logic       plc_on_q,
    input wire logic [3:0] plc_house_q,
    input wire logic [3:0] plc_unit_q
);
    logic plc_state_q [256];

    // Each receiver keeps the last on or off command sent to its codes
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            for (int i = 0; i < 256; i++) plc_state_q[i] <= 1'b0;
        else if (plc_valid_q)
            plc_state_q[{plc_house_q, plc_unit_q}] <= plc_on_q;
    end
endmodule

/* sim/oat_trigger_tb_top.sv */
// Self-checking bench for the output action trigger engine.
// Assumes a short tick so momentary and pulse runs stay brief.
`timescale 1ns/1ns
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); end end
module oat_trigger_tb_top
    import oat_pkg::*;
;
    localparam int TICK = 200; // Still longer than one scan
    logic clock, rstn = 1'b0, cfg_we = 1'b0, list_we = 1'b0, evt_valid = 1'b0;
    logic [IDX_W-1:0] cfg_addr = '0;
    oat_cfg_t cfg_wdata = '0;
    logic [3:0] list_idx = '0, evt_part = '0;
    logic [N_ZONE-1:0] list_bits = '0;
    logic [15:0] relay_addr_en = 16'h8006; // Modules 1, 2, 15; unique
    logic [31:0] annun_addr_en = 32'h0000_0200; // Lamp module 9 only
    oat_evkind_t evt_kind = EVK_ALARM;
    logic [ZONE_W-1:0] evt_zone = '0;
    logic [4:0] evt_type_or_op = '0;
    logic evt_ready_q, plc_valid_q, plc_on_q;
    logic [N_OUT-1:0] out_q;
    logic [3:0] plc_house_q, plc_unit_q;
    int fail_count = 0;
    int total_checks = 0;

    oat_trigger #(.TICK_CYCLES(TICK)) dut (.*);
    oat_out_model model (.*);

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Bounded wait for an open port; a hang ends the run
    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (evt_ready_q !== 1'b1 && n < 400);
        if (evt_ready_q !== 1'b1)
        begin
            fail_count++;
            report_and_stop();
        end
    endtask

    // Valid held until taken, then the scan is awaited
    task automatic send_evt(input oat_evkind_t k, input logic [7:0] z, input logic [4:0] t,
                            input logic [3:0] p);
        @(posedge clock);
        {evt_kind, evt_zone, evt_type_or_op, evt_part} <= {k, z, t, p};
        evt_valid <= 1'b1;
        wait_ready();
        @(posedge clock);
        evt_valid <= 1'b0;
        wait_ready();
        repeat (3) @(negedge clock);
    endtask

    task automatic wr_cfg(input int i, input oat_cfg_t c);
        @(posedge clock);
        {cfg_we, cfg_addr, cfg_wdata} <= {1'b1, 7'(i), c};
        @(posedge clock);
        cfg_we <= 1'b0;
    endtask

    function automatic oat_cfg_t mk(oat_action_t a, oat_dev_t d, logic [4:0] ad,
                                    logic [5:0] st, logic [5:0] sp);
        mk = '0;
        {mk.action, mk.dev, mk.dev_addr, mk.st_type_or_sysop, mk.sp_type_or_sysop}
            = {a, d, ad, st, sp};
    endfunction

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic s_zone;
        oat_cfg_t c;
        c = mk(ACT_LATCH, DEV_RELAY, 5'h01, 6'h00, 6'h23);
        {c.st_src, c.st_zone, c.trigger_event_select, c.sp_part}
            = {SRC_ZONE, 8'd128, EVK_ALARM, 4'h2};
        wr_cfg(0, c);
        c.action = ACT_NONE;
        wr_cfg(1, c);
        send_evt(EVK_ALARM, 8'd127, 5'h01, 4'h1);
        `CHK(out_q[0], 1'b0)
        send_evt(EVK_ALARM, 8'd128, 5'h01, 4'h1);
        `CHK(out_q[1:0], 2'b01)
        send_evt(EVK_SYSOP, 8'd0, 5'h03, 4'h5);
        `CHK(out_q[0], 1'b1)
        send_evt(EVK_SYSOP, 8'd0, 5'h03, 4'h2);
        `CHK(out_q[1:0], 2'b00)
    endtask

    task automatic s_list;
        oat_cfg_t c;
        c = mk(ACT_LATCH, DEV_RELAY, 5'h0f, 6'h0b, 6'h28);
        {c.st_src, c.zone_group_select, c.trigger_event_select, c.sp_list}
            = {SRC_LIST, 4'hf, EVK_FAULT, 4'hf};
        wr_cfg(2, c);
        @(posedge clock);
        {list_we, list_idx, list_bits} <= {1'b1, 4'hf, (129'h1 << 5) | (129'h1 << 6)};
        @(posedge clock);
        list_we <= 1'b0;
        send_evt(EVK_TROUBLE, 8'd6, 5'h01, 4'h1);
        `CHK(out_q[2], 1'b0)
        send_evt(EVK_FAULT, 8'd6, 5'h01, 4'h1);
        `CHK(out_q[2], 1'b1)
        send_evt(EVK_FAULT, 8'd5, 5'h01, 4'h1);
        send_evt(EVK_RESTORE, 8'd5, 5'h01, 4'h1);
        `CHK(out_q[2], 1'b1)
        send_evt(EVK_RESTORE, 8'd6, 5'h01, 4'h1);
        `CHK(out_q[2], 1'b0)
        send_evt(EVK_ALARM, 8'd30, 5'h0b, 4'h4);
        `CHK(out_q[2], 1'b1)
        send_evt(EVK_SYSOP, 8'd0, 5'h08, 4'h4);
        `CHK(out_q[2], 1'b0)
    endtask

    task automatic s_type;
        oat_cfg_t c;
        wr_cfg(3, mk(ACT_LATCH, DEV_RELAY, 5'h01, 6'h07, 6'h07));
        c = mk(ACT_TOGGLE, DEV_RELAY, 5'h01, 6'h09, 6'h00);
        c.st_part = 4'h3;
        wr_cfg(4, c);
        send_evt(EVK_TROUBLE, 8'd20, 5'h07, 4'h4);
        `CHK(out_q[3], 1'b1)
        send_evt(EVK_RESTORE, 8'd20, 5'h07, 4'h4);
        `CHK(out_q[3], 1'b0)
        send_evt(EVK_ALARM, 8'd21, 5'h09, 4'h3);
        `CHK(out_q[4], 1'b1)
        send_evt(EVK_ALARM, 8'd21, 5'h09, 4'h1);
        `CHK(out_q[4], 1'b1)
        send_evt(EVK_ALARM, 8'd21, 5'h09, 4'h3);
        `CHK(out_q[4], 1'b0)
    endtask

    // Disabled module addresses keep their bits low until enabled
    task automatic s_addr;
        wr_cfg(5, mk(ACT_LATCH, DEV_ANNUN, 5'h08, 6'h21, 6'h00));
        wr_cfg(10, mk(ACT_LATCH, DEV_RELAY, 5'h03, 6'h21, 6'h00));
        send_evt(EVK_SYSOP, 8'd0, 5'h01, 4'h1);
        `CHK({out_q[10], out_q[5]}, 2'b00)
        @(posedge clock);
        annun_addr_en[8] <= 1'b1;
        relay_addr_en[3] <= 1'b1;
        repeat (TICK + 110) @(negedge clock); // Enables are sampled by the next scan
        `CHK({out_q[10], out_q[5]}, 2'b11)
    endtask

    task automatic s_plc;
        oat_cfg_t c;
        c = mk(ACT_LATCH, DEV_PLC, 5'h00, 6'h22, 6'h24);
        {c.house, c.unit} = {4'h3, 4'h9};
        wr_cfg(6, c);
        send_evt(EVK_SYSOP, 8'd0, 5'h02, 4'h1);
        `CHK({out_q[6], model.plc_state_q[8'h39]}, 2'b11)
        send_evt(EVK_SYSOP, 8'd0, 5'h04, 4'h1);
        `CHK({out_q[6], model.plc_state_q[8'h39]}, 2'b00)
    endtask

    // On time is seven to eight ticks of 200 cycles
    task automatic s_moment;
        wr_cfg(7, mk(ACT_MOMENT, DEV_RELAY, 5'h01, 6'h25, 6'h00));
        send_evt(EVK_SYSOP, 8'd0, 5'h05, 4'h1);
        `CHK(out_q[7], 1'b1)
        repeat (1300) @(negedge clock);
        `CHK(out_q[7], 1'b1)
        repeat (600) @(negedge clock);
        `CHK(out_q[7], 1'b0)
    endtask

    // Relay output blinks each tick; lamp output stays steady
    task automatic s_pulse;
        int tg;
        logic prev, steady;
        wr_cfg(8, mk(ACT_PULSE, DEV_RELAY, 5'h02, 6'h26, 6'h27));
        wr_cfg(9, mk(ACT_PULSE, DEV_ANNUN, 5'h09, 6'h26, 6'h27));
        send_evt(EVK_SYSOP, 8'd0, 5'h06, 4'h1);
        {tg, prev, steady} = {32'd0, out_q[8], 1'b1};
        repeat (1100)
        begin
            @(negedge clock);
            tg += (out_q[8] !== prev) ? 1 : 0;
            prev = out_q[8];
            steady &= out_q[9];
        end
        `CHK((tg >= 4) && (tg <= 6), 1'b1)
        `CHK(steady, 1'b1)
        send_evt(EVK_SYSOP, 8'd0, 5'h07, 4'h1);
        `CHK(out_q[9:8], 2'b00)
    endtask

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Store has no reset: write every word before events
    initial
    begin
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < N_OUT; i++)
            wr_cfg(i, mk(ACT_NONE, DEV_OFF, 5'h00, 6'h00, 6'h00));
        s_zone();
        s_list();
        s_type();
        s_addr();
        s_plc();
        s_moment();
        s_pulse();
        report_and_stop();
    end
endmodule
